//--- hdl/pds_sampler.sv
// pc / data address sampler: counter, capture, register port and scan side
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "pds_defs.svh"
module pds_sampler #(
  parameter bit PC_IMPL = 1'b1,
  parameter bit DA_IMPL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`PDS_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic gradValid,
  input wire logic [`PDS_PC_W-1:0] gradPc,
  input wire logic fetchMiss,
  input wire logic [`PDS_PC_W-1:0] fetchPc,
  input wire logic lsValid,
  input wire logic [`PDS_PC_W-1:0] lsAddr,
  input wire logic dbp0Hit,
  input wire logic [`PDS_ID_W-1:0] spaceId,
  input wire logic inWait,
  input wire logic tck,
  input wire logic trst_b,
  input wire logic sampleSel,
  input wire logic captureDr,
  input wire logic shiftDr,
  input wire logic tdi,
  output logic tdo
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (2 * `PDS_SMP_W != `PDS_SCAN_W) begin : g_chk
    $error("scan width must hold two samples");
  end

  // ----------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------
  pds_pkg::pds_core_s c_ff;
  pds_pkg::pds_core_s nxt_c;
  pds_pkg::pds_tap_s t_ff;
  pds_pkg::pds_tap_s nxt_t;

  logic smpOn;
  logic expire;
  logic [`PDS_CNT_W-1:0] lastCnt;
  logic ackEdge;
  logic rdEdge;
  logic stored;
  logic [`PDS_LEN_W-1:0] smpLen;
  logic [`PDS_LEN_W-1:0] pcLen;
  logic [`PDS_LEN_W-1:0] daLen;
  logic [`PDS_SCAN_W-1:0] pcPart;
  logic [`PDS_SCAN_W-1:0] daPart;

  always_comb begin
    nxt_c = c_ff;
    // synchronisers; first stage only feeds the second
    nxt_c.ackS1 = t_ff.ackTgl;
    nxt_c.ackS2 = c_ff.ackS1;
    nxt_c.ackSeen = c_ff.ackS2;
    nxt_c.rdS1 = t_ff.readTgl;
    nxt_c.rdS2 = c_ff.rdS1;
    nxt_c.rdSeen = c_ff.rdS2;
    ackEdge = c_ff.ackS2 ^ c_ff.ackSeen;
    rdEdge = c_ff.rdS2 ^ c_ff.rdSeen;
    stored = 1'b0;

    // ---------------- counter ----------------
    smpOn = c_ff.pcOn | c_ff.daOn; // R1 R9
    lastCnt = `PDS_CNT_W'((13'h1 << (`PDS_RATE_BASE + c_ff.rate)) - 13'h1); // R4
    expire = smpOn && !inWait && (c_ff.cnt == lastCnt); // R11 R16
    if (!smpOn) begin
      nxt_c.cnt = '0;
    end else if (inWait) begin
      nxt_c.cnt = c_ff.cnt; // R11
    end else if (expire) begin
      nxt_c.cnt = '0; // R16
    end else begin
      nxt_c.cnt = c_ff.cnt + `PDS_CNT_W'(1); // R16
    end

    // ---------------- candidate tracking ----------------
    if (fetchMiss) begin
      nxt_c.lastMiss = fetchPc; // R12
    end
    if (lsValid && (!c_ff.qual || dbp0Hit)) begin
      nxt_c.lastLs = lsAddr; // R13 R14
    end

    // ---------------- capture ----------------
    if (c_ff.pcPend && gradValid) begin
      nxt_c.pcVal = gradPc; // R8
      nxt_c.pcId = spaceId;
      nxt_c.pcPend = 1'b0;
      stored = 1'b1;
    end
    if (expire && c_ff.pcOn) begin
      if (c_ff.missOnly) begin
        nxt_c.pcVal = c_ff.lastMiss; // R12
        nxt_c.pcId = spaceId;
        nxt_c.pcPend = 1'b0;
        stored = 1'b1;
      end else if (gradValid) begin
        nxt_c.pcVal = gradPc; // R8
        nxt_c.pcId = spaceId;
        nxt_c.pcPend = 1'b0;
        stored = 1'b1;
      end else begin
        nxt_c.pcPend = 1'b1; // R8
      end
    end
    if (expire && c_ff.daOn) begin
      nxt_c.daVal = c_ff.lastLs; // R15
      nxt_c.daId = spaceId;
      stored = 1'b1;
    end
    if (!c_ff.pcOn) begin
      nxt_c.pcPend = 1'b0;
    end

    // ---------------- new flag ----------------
    // set beats the probe's clear in the same cycle
    if (rdEdge) begin
      nxt_c.newFlag = 1'b0;
    end
    if (stored) begin
      nxt_c.newFlag = 1'b1; // R7
      nxt_c.dirty = 1'b1; // R2
    end else if (inWait && smpOn && (rdEdge || !c_ff.newFlag)) begin
      nxt_c.newFlag = 1'b1; // R11
      nxt_c.dirty = 1'b1; // R11
    end

    // ---------------- scan image ----------------
    smpLen = c_ff.noId ? `PDS_LEN_W'(`PDS_PC_W + 1) : `PDS_LEN_W'(`PDS_SMP_W); // R6
    pcLen = c_ff.pcOn ? smpLen : '0; // R10
    daLen = c_ff.daOn ? smpLen : '0; // R10
    pcPart = '0;
    daPart = '0;
    pcPart[`PDS_PC_W:1] = nxt_c.pcVal; // R6
    daPart[`PDS_PC_W:1] = nxt_c.daVal; // R6
    if (!c_ff.noId) begin
      pcPart[`PDS_SMP_W-1:`PDS_PC_W+1] = nxt_c.pcId; // R6
      daPart[`PDS_SMP_W-1:`PDS_PC_W+1] = nxt_c.daId; // R6
    end
    if (!c_ff.pcOn) begin
      pcPart = '0;
    end
    if (!c_ff.daOn) begin
      daPart = '0;
    end

    // ---------------- push to scan side ----------------
    // only one word in flight; a later sample waits and replaces it
    if (ackEdge) begin
      nxt_c.busy = 1'b0;
    end
    if (c_ff.dirty && !c_ff.busy) begin
      nxt_c.xWord = pcPart | (daPart << pcLen); // R10 R2
      nxt_c.xPcLen = pcLen;
      nxt_c.xTotLen = pcLen + daLen;
      nxt_c.reqTgl = ~c_ff.reqTgl;
      nxt_c.busy = 1'b1;
      nxt_c.dirty = stored || nxt_c.dirty && c_ff.dirty && stored;
    end

    // ---------------- register port ----------------
    nxt_c.rdata = '0;
    if (regRd) begin
      unique case (regAddr)
        `PDS_OFS_CTRL: begin
          nxt_c.rdata[`PDS_BIT_PC_ON] = c_ff.pcOn;
          nxt_c.rdata[`PDS_RATE_HI:`PDS_RATE_LO] = c_ff.rate;
          nxt_c.rdata[`PDS_BIT_PC_HAS] = PC_IMPL; // R1
          nxt_c.rdata[`PDS_BIT_DA_HAS] = DA_IMPL; // R3
          nxt_c.rdata[`PDS_BIT_DA_ON] = c_ff.daOn;
          nxt_c.rdata[`PDS_BIT_QUAL] = c_ff.qual;
          nxt_c.rdata[`PDS_BIT_NO_ID] = c_ff.noId;
          nxt_c.rdata[`PDS_BIT_MISS] = c_ff.missOnly;
        end
        `PDS_OFS_STAT: begin
          nxt_c.rdata[`PDS_CNT_W-1:0] = c_ff.cnt;
          nxt_c.rdata[16] = c_ff.newFlag;
          nxt_c.rdata[17] = c_ff.pcPend;
          nxt_c.rdata[18] = c_ff.busy;
        end
        default: begin
          nxt_c.rdata = '0;
        end
      endcase
    end
    if (regWr && regAddr == `PDS_OFS_CTRL) begin
      nxt_c.pcOn = regWdata[`PDS_BIT_PC_ON] & PC_IMPL; // R1
      nxt_c.daOn = regWdata[`PDS_BIT_DA_ON] & DA_IMPL; // R3
      nxt_c.rate = regWdata[`PDS_RATE_HI:`PDS_RATE_LO]; // R4
      nxt_c.qual = regWdata[`PDS_BIT_QUAL]; // R13
      nxt_c.noId = regWdata[`PDS_BIT_NO_ID]; // R6
      nxt_c.missOnly = regWdata[`PDS_BIT_MISS]; // R12
      nxt_c.cnt = '0; // R5
      nxt_c.pcPend = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      c_ff <= '0;
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign regRdata = c_ff.rdata;

  // ----------------------------------------------------------------
  // scan domain
  // ----------------------------------------------------------------
  logic reqEdge;
  logic doCapture;
  logic [`PDS_SCAN_W-1:0] image;
  logic [`PDS_LEN_W-1:0] inPos;

  always_comb begin
    nxt_t = t_ff;
    nxt_t.reqS1 = c_ff.reqTgl;
    nxt_t.reqS2 = t_ff.reqS1;
    nxt_t.reqSeen = t_ff.reqS2;
    reqEdge = t_ff.reqS2 ^ t_ff.reqSeen;
    doCapture = sampleSel && captureDr;
    inPos = '0;

    // new flag goes in at bit 0 of each present sample
    image = t_ff.hold;
    if (t_ff.holdTotLen != '0) begin
      image[0] = t_ff.holdNew; // R7
    end
    if (t_ff.holdPcLen < t_ff.holdTotLen && t_ff.holdPcLen != '0) begin
      image[t_ff.holdPcLen] = t_ff.holdNew; // R7 R10
    end

    if (doCapture) begin
      nxt_t.sh = image;
      nxt_t.readTgl = ~t_ff.readTgl; // R7
      nxt_t.holdNew = 1'b0;
    end else if (sampleSel && shiftDr) begin
      // tdi enters at the top of the live length only
      inPos = (t_ff.holdTotLen == '0) ? '0 : t_ff.holdTotLen - `PDS_LEN_W'(1); // R10
      nxt_t.sh = t_ff.sh >> 1;
      nxt_t.sh[inPos] = tdi;
    end
    if (reqEdge) begin
      nxt_t.hold = c_ff.xWord; // R2
      nxt_t.holdPcLen = c_ff.xPcLen;
      nxt_t.holdTotLen = c_ff.xTotLen;
      nxt_t.holdNew = 1'b1; // R7
      nxt_t.ackTgl = ~t_ff.ackTgl;
    end
  end

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      t_ff <= '0;
    end else begin
      t_ff <= nxt_t;
    end
  end

  assign tdo = t_ff.sh[0];

endmodule : pds_sampler

//--- hdl/pds_defs.svh
// constants of the pc / data address sampler
//
// Functional notes
// R1 - pc sampling presence bit reported; sampling only while its enable bit is one
// R2 - each new sample overwrites the held scan value, read or not
// R3 - data sampling has presence bit; enable bit 23 adds data sample to scan
// R4 - rate field bits 8:6 selects period 2^5 .. 2^12 core clocks
// R5 - every write of the rate field restarts the sample counter
// R6 - sample holds new flag, value, space id; id dropped when bit 25 set
// R7 - device sets new flag on fresh sample; probe discards already-read samples
// R8 - capture graduating pc at expiry; if stalled, next graduating pc
// R9 - sampling keeps running in debug mode
// R10 - scan holds only enabled samples, pc low, data above it
// R11 - in wait state stop counting, re-set new flag whenever probe clears it
// R12 - miss-only bit 26 stores most recent cache-missing fetch at expiry
// R13 - qualify bit limits data capture to accesses hitting data breakpoint 0
// R14 - software enables trigger of data breakpoint 0 before qualifying
// R15 - shared counter paces data sampling; latest load/store address latched
// R16 - counter counts while enabled, signals expiry and restarts each period
`ifndef PDS_DEFS_SVH
`define PDS_DEFS_SVH
`define PDS_PC_W 32
`define PDS_ID_W 8
`define PDS_SMP_W 41
`define PDS_SCAN_W 82
`define PDS_LEN_W 7
`define PDS_CNT_W 12
`define PDS_RATE_BASE 5
`define PDS_ADDR_W 4
`define PDS_OFS_CTRL 4'h0
`define PDS_OFS_STAT 4'h4
`define PDS_BIT_PC_ON 5
`define PDS_RATE_LO 6
`define PDS_RATE_HI 8
`define PDS_BIT_PC_HAS 9
`define PDS_BIT_DA_HAS 22
`define PDS_BIT_DA_ON 23
`define PDS_BIT_QUAL 24
`define PDS_BIT_NO_ID 25
`define PDS_BIT_MISS 26
`define PDS_RST_RATE 3'h0
`endif

//--- hdl/pds_pkg.sv
// types of the pc / data address sampler
`include "pds_defs.svh"
package pds_pkg;
  typedef struct packed {
    logic ackS1;
    logic ackS2;
    logic ackSeen;
    logic rdS1;
    logic rdS2;
    logic rdSeen;
    logic pcOn;
    logic daOn;
    logic [2:0] rate;
    logic qual;
    logic noId;
    logic missOnly;
    logic [`PDS_CNT_W-1:0] cnt;
    logic pcPend;
    logic [`PDS_PC_W-1:0] lastMiss;
    logic [`PDS_PC_W-1:0] lastLs;
    logic [`PDS_PC_W-1:0] pcVal;
    logic [`PDS_ID_W-1:0] pcId;
    logic [`PDS_PC_W-1:0] daVal;
    logic [`PDS_ID_W-1:0] daId;
    logic newFlag;
    logic dirty;
    logic busy;
    logic reqTgl;
    logic [`PDS_SCAN_W-1:0] xWord;
    logic [`PDS_LEN_W-1:0] xPcLen;
    logic [`PDS_LEN_W-1:0] xTotLen;
    logic [31:0] rdata;
  } pds_core_s;

  typedef struct packed {
    logic reqS1;
    logic reqS2;
    logic reqSeen;
    logic ackTgl;
    logic readTgl;
    logic holdNew;
    logic [`PDS_SCAN_W-1:0] hold;
    logic [`PDS_LEN_W-1:0] holdPcLen;
    logic [`PDS_LEN_W-1:0] holdTotLen;
    logic [`PDS_SCAN_W-1:0] sh;
  } pds_tap_s;
endpackage : pds_pkg

//--- tb/pds_assertions.sv
// port checks for the sampler, bound into its top
`timescale 1ns/1ps
`include "pds_defs.svh"
module pds_checker #(
  parameter bit PC_IMPL = 1'b1,
  parameter bit DA_IMPL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`PDS_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic inWait
);
  logic onFf;
  logic [2:0] rateFf;
  logic ctlWr;
  logic rdCt;
  logic rdSt;
  assign ctlWr = regWr && regAddr == `PDS_OFS_CTRL;
  assign rdCt = regRd && regAddr == `PDS_OFS_CTRL;
  assign rdSt = regRd && regAddr == `PDS_OFS_STAT;
  // shadow of the live rate, so the counter bound follows each write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      onFf <= 1'b0;
      rateFf <= 3'h0;
    end else if (ctlWr) begin
      onFf <= (regWdata[5] && PC_IMPL) || (regWdata[23] && DA_IMPL);
      rateFf <= regWdata[8:6];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_pc_present: assert property (rdCt |=> regRdata[9] == PC_IMPL)
    else $error("pc present bit wrong");
  a_pc_enable: assert property (ctlWr ##2 rdCt |=>
    regRdata[5] == ($past(regWdata[5], 3) && PC_IMPL)) else $error("pc enable wrong");
  a_da_enable: assert property (ctlWr ##2 rdCt |=>
    regRdata[23] == ($past(regWdata[23], 3) && DA_IMPL)) else $error("data enable wrong");
  a_rate_readback: assert property (ctlWr ##2 rdCt |=>
    regRdata[8:6] == $past(regWdata[8:6], 3)) else $error("rate readback wrong");
  a_count_restart: assert property (ctlWr ##2 rdSt |=> regRdata[11:0] <= 12'h2)
    else $error("counter not restarted");
  a_count_bound: assert property (rdSt |=>
    regRdata[11:0] <= (12'hfff >> (3'h7 - $past(rateFf)))) else $error("counter past period");
  a_wait_hold: assert property (inWait && rdSt ##1 rdSt |=>
    regRdata[11:0] == $past(regRdata[11:0])) else $error("counter moved in wait");
  a_count_step: assert property (onFf && !inWait && rdSt ##1 rdSt |=>
    regRdata[11:0] == $past(regRdata[11:0]) + 12'h1 || regRdata[11:0] == 12'h0)
    else $error("counter step wrong");
  c_ctl_write: cover property (ctlWr);
  c_wait_read: cover property (inWait && rdSt ##1 rdSt);
  c_count_read: cover property (onFf && !inWait && rdSt ##1 rdSt);
endmodule : pds_checker

bind pds_sampler pds_checker #(.PC_IMPL(PC_IMPL), .DA_IMPL(DA_IMPL)) u_chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr),
  .regRd(regRd),
  .regRdata(regRdata),
  .inWait(inWait)
);

//--- tb/pds_probe.sv
// probe model that scans the sample register over the test port
`timescale 1ns/1ps
module pds_probe (
  output logic tck,
  output logic sampleSel,
  output logic captureDr,
  output logic shiftDr,
  output logic tdi,
  input wire logic tdo
);
  initial tck = 1'b0;
  initial sampleSel = 1'b0;
  initial captureDr = 1'b0;
  initial shiftDr = 1'b0;
  initial tdi = 1'b0;
  // tck runs only inside scan, 28 idle ticks then the frame; tdi held low so bits past the live length shift out zero
  task automatic pulse();
    #15 tck = 1'b0;
    #16 tck = 1'b1;
    #1 tdi = 1'b0;
  endtask : pulse
  // idle ticks first let the crossing retire a stale word and deliver the latest
  task automatic scan(output logic [81:0] v);
    v = 82'h0;
    repeat (28) pulse();
    sampleSel = 1'b1;
    captureDr = 1'b1;
    pulse();
    captureDr = 1'b0;
    shiftDr = 1'b1;
    for (int i = 0; i < 82; i++) begin
      v[i] = tdo;
      pulse();
    end
    shiftDr = 1'b0;
    sampleSel = 1'b0;
    #15 tck = 1'b0;
  endtask : scan
endmodule : pds_probe

//--- tb/pds_sampler_tb.sv
// self-checking bench for the pc / data address sampler
`timescale 1ns/1ps
`include "pds_defs.svh"
module pds_sampler_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic trst_b;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, gradPc = 32'h0, fetchPc = 32'h0, lsAddr = 32'h0;
  logic regWr = 1'b0, regRd = 1'b0, fetchMiss = 1'b0, dbp0Hit = 1'b0, inWait = 1'b0;
  logic gradValid = 1'b1, lsValid = 1'b1;
  logic [7:0] spaceId = 8'h0;
  logic tck, sampleSel, captureDr, shiftDr, tdi, tdo;
  int n_fail = 0;
  int check_count = 0;
  localparam logic [31:0] ROWS [8] = '{32'h00000020, 32'h02000060, 32'h008000a0,
    32'h028000e0, 32'h00800100, 32'h00000160, 32'h008001a0, 32'h000001e0};
  assign trst_b = rst_b;
  always #50 core_clk = ~core_clk;
  pds_sampler u_dut (.*);
  pds_probe u_probe (.*);
  task automatic chk(input string what, input logic [81:0] exp, input logic [81:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= `PDS_OFS_CTRL;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic pair(output logic [31:0] a, output logic [31:0] b);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= `PDS_OFS_STAT;
    @(posedge core_clk);
    #1 a = regRdata;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 b = regRdata;
  endtask : pair
  function automatic logic [81:0] word(input logic [31:0] c, input logic [31:0] p,
      input logic [31:0] a);
    logic [81:0] sp;
    logic [81:0] sd;
    sp = c[25] ? {49'h0, p, 1'b1} : {41'h0, spaceId, p, 1'b1};
    sd = c[25] ? {49'h0, a, 1'b1} : {41'h0, spaceId, a, 1'b1};
    if (!c[5]) return c[23] ? sd : 82'h0;
    return c[23] ? (sd << (c[25] ? 33 : 41)) | sp : sp;
  endfunction : word
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    #3000000;
    n_fail++;
    stop_test();
  end
  // ----------------------------------------
  // table rows, then the awkward cases
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [31:0] e;
    logic [81:0] v;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`PDS_OFS_CTRL, d);
    chk("reset ctrl", 82'h00400200, 82'(d));
    rd(4'h8, d);
    chk("unmapped", 82'h0, 82'(d));
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      gradPc <= 32'h10000000 + 32'(i);
      lsAddr <= 32'h20000000 + 32'(i);
      spaceId <= 8'h30 + 8'(i);
      wr(ROWS[i]);
      rd(`PDS_OFS_CTRL, d);
      chk("ctrl", 82'(ROWS[i] | 32'h00400200), 82'(d));
      pair(d, e);
      chk("step", 82'(d[11:0] + 12'h1), 82'(e[11:0]));
      repeat ((32 << ROWS[i][8:6]) + 8) @(posedge core_clk);
      u_probe.scan(v);
      chk("scan", word(ROWS[i], gradPc, lsAddr), v);
      $display("row %0d done", i);
    end
    u_probe.scan(v);
    chk("reread", word(ROWS[7], gradPc, lsAddr) & ~82'h1, v);
    wr(32'h000001e0);
    rd(`PDS_OFS_STAT, d);
    chk("restart", 82'h1, 82'(d[11:0] <= 12'h2));
    @(posedge core_clk);
    inWait <= 1'b1;
    wr(32'h00000020);
    pair(d, e);
    chk("wait hold", 82'(d[11:0]), 82'(e[11:0]));
    repeat (2) begin
      u_probe.scan(v);
      chk("wait new", 82'h1, 82'(v[0]));
    end
    inWait <= 1'b0;
    wr(32'h00000020);
    gradValid <= 1'b0;
    repeat (40) @(posedge core_clk);
    gradPc <= 32'h00008888;
    gradValid <= 1'b1;
    @(posedge core_clk);
    gradValid <= 1'b0;
    gradPc <= 32'h0;
    repeat (40) @(posedge core_clk);
    u_probe.scan(v);
    chk("stall pc", word(32'h20, 32'h8888, 32'h0), v);
    gradValid <= 1'b1;
    wr(32'h04000020);
    fetchMiss <= 1'b1;
    fetchPc <= 32'h00004444;
    @(posedge core_clk);
    fetchMiss <= 1'b0;
    fetchPc <= 32'h00005555;
    repeat (40) @(posedge core_clk);
    u_probe.scan(v);
    chk("miss pc", word(32'h20, 32'h4444, 32'h0), v);
    wr(32'h01800000);
    lsAddr <= 32'h00007777;
    dbp0Hit <= 1'b1;
    @(posedge core_clk);
    dbp0Hit <= 1'b0;
    lsAddr <= 32'h00005555;
    repeat (40) @(posedge core_clk);
    u_probe.scan(v);
    chk("qualified", word(32'h00800000, 32'h0, 32'h7777), v);
    $display("hand tests done");
    stop_test();
  end
endmodule : pds_sampler_tb
